/* gx_pkg.sv */
// Purpose: Shared constants and types for the I/O expander slave and its bus master.
// Assumes: One 250 MHz clock on both ends; the serial link runs at 400 kHz.
// Notes:   Rules carried by both ends are listed below.
// What this block does
// - Master holds reset line low long enough
// - Reset low forces registers and fsm default
// - Pins change only while reset high
// - Input pin edge asserts attention line
// - Release on data return or port read
// - Read clear at acknowledge clock rise
// - Change during acknowledge pulse may vanish
// - Every later change raises attention again
// - Traffic to other slaves ignored
// - Output pins never raise attention
// - Output-to-input switch may raise attention
// - Attention line open drain, low active
// - Write uses direction bit zero
// - Command byte follows address, selects register
// - Unlimited data bytes per write
// - Read: command, restart, address with one
// - Data captured at acknowledge clock rise
// - Stop anytime; last acknowledged data stays
// - Direct read streams register of stored command
// - Address 0x20 or 0x21 by select pin
// - Direction bit one input, zero output
package gx_pkg;

    // Bus addressing
    localparam logic [5:0] ADDR_BASE   = 6'h10;   // Upper six bits of 0x20 / 0x21
    localparam logic       DIR_WRITE   = 1'h0;
    localparam logic       DIR_READ    = 1'h1;

    // Register selectors carried in the command byte
    localparam logic [1:0] REG_INPUT   = 2'h0;
    localparam logic [1:0] REG_OUTPUT  = 2'h1;
    localparam logic [1:0] REG_POL     = 2'h2;
    localparam logic [1:0] REG_CFG     = 2'h3;

    // Reset values
    localparam logic [7:0] OUT_RST     = 8'hff;
    localparam logic [7:0] POL_RST     = 8'h00;
    localparam logic [7:0] CFG_RST     = 8'hff;
    localparam logic [1:0] CMD_RST     = 2'h0;

    // Master operations
    localparam logic [1:0] OP_WRITE    = 2'h0;
    localparam logic [1:0] OP_READ     = 2'h1;
    localparam logic [1:0] OP_DIRECT   = 2'h2;
    localparam logic [1:0] OP_RESET    = 2'h3;

    // Timing
    localparam int CLK_MHZ                   = 250;
    localparam int SCL_KHZ                   = 400;
    localparam int QUARTER_CYC               = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
    localparam int RESET_PULSE_MIN_WIDTH_NS  = 1000;
    localparam int RESET_PULSE_CYC           = (RESET_PULSE_MIN_WIDTH_NS * CLK_MHZ + 999) / 1000;
    // Clocks for the pin filter to fill after reset before levels are trusted
    localparam logic [2:0] SETTLE_CYC        = 3'h4;

    // Slave bus states
    typedef enum logic [3:0] {
        D_IDLE, D_ADDR, D_ACK_A, D_CMD, D_ACK_C, D_WR, D_ACK_W, D_RD, D_ACK_R
    } gx_dst_e;

    // Master states and sequence item kinds
    typedef enum logic [2:0] {M_IDLE, M_START, M_BYTE, M_STOP, M_RESET} gx_mst_e;
    typedef enum logic [1:0] {K_START, K_TX, K_RX, K_STOP} gx_kind_e;

endpackage

/* gx_if.sv */
// Purpose: Serial link, reset line and attention line between master and expander.
// Assumes: Clock, data and attention lines are pulled up; each end only pulls low through its enable.
// Notes:   Wired-AND resolution is done here, so the ends never see high impedance.
`timescale 1ns/1ps
interface gx_if;
    logic m_scl_oe;   // Master pulls clock low
    logic m_sda_oe;   // Master pulls data low
    logic s_sda_oe;   // Slave pulls data low
    logic s_int_oe;   // Slave pulls attention low
    logic rst_n;      // Reset line driven by master
    logic scl;
    logic sda;
    logic int_n;

    // Open-drain lines with pullups
    assign scl   = ~m_scl_oe;
    assign sda   = ~(m_sda_oe | s_sda_oe);
    assign int_n = ~s_int_oe;

    modport dev  (input scl, sda, rst_n, output s_sda_oe, s_int_oe);
    modport host (input scl, sda, int_n, output m_scl_oe, m_sda_oe, rst_n);
endinterface

/* gx_expander.sv */
// Purpose: Slave end: eight-pin I/O expander with change attention and reset line.
// Assumes: Link lines and pins are asynchronous and pass a three-stage filter.
// Notes:   No clock stretching; each serial quarter period must exceed five clocks.
`timescale 1ns/1ps
module gx_expander (
    // Clock and reset
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_N,
    // Link
    gx_if.dev               bus,
    // Port pins and address strap
    input  wire logic [7:0] I_P,
    output      logic [7:0] O_P,
    output      logic [7:0] O_P_OE,
    input  wire logic       I_ADDR_SEL
);

    // Bit order of the synchronised vector
    localparam int SY_W = 12;
    localparam logic [SY_W-1:0] SYNC_RST = 12'hfff;

    typedef struct packed {
        gx_pkg::gx_dst_e st;
        logic [3:0]      cnt;
        logic [7:0]      sh;
        logic            rw;
        logic            nack;
        logic [1:0]      cmd;
        logic [7:0]      outp;
        logic [7:0]      pol;
        logic [7:0]      cfg;
        logic [7:0]      snap;
        logic            primed;
        logic [2:0]      settle;
        logic            sda_oe;
        logic            int_oe;
    } gx_dev_s;

    localparam gx_dev_s DEV_RST = '{
        st: gx_pkg::D_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0, nack: 1'b0,
        cmd: gx_pkg::CMD_RST, outp: gx_pkg::OUT_RST, pol: gx_pkg::POL_RST,
        cfg: gx_pkg::CFG_RST, snap: 8'h00, primed: 1'b0, settle: 3'h0, sda_oe: 1'b0,
        int_oe: 1'b0};

    logic [SY_W-1:0] sy1;
    logic [SY_W-1:0] sy2;
    logic [SY_W-1:0] sy3;
    logic [SY_W-1:0] filt;
    logic [SY_W-1:0] next_filt;
    gx_dev_s         r;
    gx_dev_s         next_r;

    logic       scl_f;
    logic       sda_f;
    logic       rstn_f;
    logic       addr_f;
    logic [7:0] pin_f;
    logic       scl_n;
    logic       sda_n;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [7:0] in_val;
    logic [7:0] rd_val;

    // Three-stage input filter: a level counts once stages two and three agree
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sy1  <= SYNC_RST;
            sy2  <= SYNC_RST;
            sy3  <= SYNC_RST;
            filt <= SYNC_RST;
        end else begin
            sy1  <= {bus.scl, bus.sda, bus.rst_n, I_ADDR_SEL, I_P};
            sy2  <= sy1;
            sy3  <= sy2;
            filt <= next_filt;
        end
    end

    // Per bit: take the new level only when stages agree, else hold
    always_comb begin
        next_filt = ((sy2 ^ sy3) & filt) | (~(sy2 ^ sy3) & sy3);
    end

    assign scl_f  = filt[11];
    assign sda_f  = filt[10];
    assign rstn_f = filt[9];
    assign addr_f = filt[8];
    assign pin_f  = filt[7:0];
    assign scl_n  = next_filt[11];
    assign sda_n  = next_filt[10];

    // Bus events seen one cycle before the filtered copy moves
    assign scl_rise = ~scl_f & scl_n;
    assign scl_fall = scl_f & ~scl_n;
    assign start_c  = scl_f & scl_n & sda_f & ~sda_n;
    assign stop_c   = scl_f & scl_n & ~sda_f & sda_n;

    // Input port value as read over the bus, with polarity applied
    assign in_val = pin_f ^ r.pol;

    // Register selected by the stored command for a read
    always_comb begin
        case (r.cmd)
            gx_pkg::REG_INPUT:  rd_val = in_val;
            gx_pkg::REG_OUTPUT: rd_val = r.outp;
            gx_pkg::REG_POL:    rd_val = r.pol;
            default:            rd_val = r.cfg;
        endcase
    end

    // Bus state, registers and attention snapshot
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            r <= DEV_RST;
        end else begin
            r <= next_r;
        end
    end

    // Next state of the slave; reset line low overrides everything
    always_comb begin
        next_r = r;
        if (!rstn_f) begin
            next_r = DEV_RST;
        end else begin
            // Filter resets to ones, so wait until it holds real pin levels
            if (!r.primed) begin
                if (r.settle == gx_pkg::SETTLE_CYC) begin
                    next_r.snap   = pin_f;
                    next_r.primed = 1'b1;
                end else begin
                    next_r.settle = r.settle + 3'h1;
                end
            end
            if (stop_c) begin
                next_r.st     = gx_pkg::D_IDLE;
                next_r.sda_oe = 1'b0;
            end else if (start_c) begin
                // Repeated start lands here too, keeping the stored command
                next_r.st     = gx_pkg::D_ADDR;
                next_r.cnt    = 4'h0;
                next_r.sda_oe = 1'b0;
            end else if (scl_rise) begin
                case (r.st)
                    gx_pkg::D_ADDR, gx_pkg::D_CMD, gx_pkg::D_WR: begin
                        next_r.sh  = {r.sh[6:0], sda_f};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    gx_pkg::D_ACK_C: begin
                        next_r.cmd = r.sh[1:0];
                    end
                    gx_pkg::D_ACK_W: begin
                        // Commit on the acknowledge clock rise; a stop before it discards
                        case (r.cmd)
                            gx_pkg::REG_OUTPUT: next_r.outp = r.sh;
                            gx_pkg::REG_POL:    next_r.pol  = r.sh;
                            gx_pkg::REG_CFG:    next_r.cfg  = r.sh;
                            default:            next_r.outp = r.outp;
                        endcase
                    end
                    gx_pkg::D_ACK_R: begin
                        next_r.nack = sda_f;
                        // Reading the input port re-arms the change detector
                        if (r.cmd == gx_pkg::REG_INPUT) begin
                            next_r.snap = pin_f;
                        end
                    end
                    default: begin
                        next_r.nack = r.nack;
                    end
                endcase
            end else if (scl_fall) begin
                case (r.st)
                    gx_pkg::D_ADDR: begin
                        if (r.cnt == 4'h8) begin
                            if (r.sh[7:1] == {gx_pkg::ADDR_BASE, addr_f}) begin
                                next_r.st     = gx_pkg::D_ACK_A;
                                next_r.sda_oe = 1'b1;
                                next_r.rw     = r.sh[0];
                            end else begin
                                next_r.st = gx_pkg::D_IDLE;
                            end
                        end
                    end
                    gx_pkg::D_CMD: begin
                        if (r.cnt == 4'h8) begin
                            next_r.st     = gx_pkg::D_ACK_C;
                            next_r.sda_oe = 1'b1;
                        end
                    end
                    gx_pkg::D_WR: begin
                        if (r.cnt == 4'h8) begin
                            next_r.st     = gx_pkg::D_ACK_W;
                            next_r.sda_oe = 1'b1;
                        end
                    end
                    gx_pkg::D_ACK_A: begin
                        if (r.rw == gx_pkg::DIR_READ) begin
                            // Direct read uses whatever command is stored
                            next_r.st     = gx_pkg::D_RD;
                            next_r.sh     = rd_val;
                            next_r.cnt    = 4'h0;
                            next_r.sda_oe = ~rd_val[7];
                        end else begin
                            next_r.st     = gx_pkg::D_CMD;
                            next_r.cnt    = 4'h0;
                            next_r.sda_oe = 1'b0;
                        end
                    end
                    gx_pkg::D_ACK_C, gx_pkg::D_ACK_W: begin
                        // Any number of data bytes land in the same register
                        next_r.st     = gx_pkg::D_WR;
                        next_r.cnt    = 4'h0;
                        next_r.sda_oe = 1'b0;
                    end
                    gx_pkg::D_RD: begin
                        if (r.cnt == 4'h7) begin
                            next_r.st     = gx_pkg::D_ACK_R;
                            next_r.sda_oe = 1'b0;
                        end else begin
                            next_r.sh     = {r.sh[6:0], 1'b0};
                            next_r.cnt    = r.cnt + 4'h1;
                            next_r.sda_oe = ~r.sh[6];
                        end
                    end
                    gx_pkg::D_ACK_R: begin
                        if (r.nack) begin
                            next_r.st = gx_pkg::D_IDLE;
                        end else begin
                            // Stream the same register again with fresh contents
                            next_r.st     = gx_pkg::D_RD;
                            next_r.sh     = rd_val;
                            next_r.cnt    = 4'h0;
                            next_r.sda_oe = ~rd_val[7];
                        end
                    end
                    default: begin
                        next_r.st = r.st;
                    end
                endcase
            end
            // Attention: input pins that differ from the snapshot; outputs masked
            next_r.int_oe = r.primed & (|((pin_f ^ next_r.snap) & next_r.cfg));
        end
    end

    // Open-drain drives: only ever pull low
    assign bus.s_sda_oe = r.sda_oe;
    assign bus.s_int_oe = r.int_oe;

    // Port pins: output latch always visible, driver enabled where direction is zero
    assign O_P    = r.outp;
    assign O_P_OE = ~r.cfg;

endmodule

/* gx_master.sv */
// Purpose: Master end: runs write, read, direct read and reset pulses on the link.
// Assumes: One data byte per request; the slave never stretches the clock.
// Notes:   A missing acknowledge on a sent byte ends the transfer with a stop.
`timescale 1ns/1ps
module gx_master #(
    parameter int QUARTER = gx_pkg::QUARTER_CYC,
    parameter int RST_CYC = gx_pkg::RESET_PULSE_CYC
) (
    // Clock and reset
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_N,
    // Request
    input  wire logic       I_REQ,
    input  wire logic [1:0] I_OP,
    input  wire logic       I_ADDR_SEL,
    input  wire logic [7:0] I_CMD,
    input  wire logic [7:0] I_WDATA,
    output      logic       O_READY,
    // Answer
    output      logic       O_DONE,
    output      logic       O_NACK,
    output      logic [7:0] O_RDATA,
    output      logic       O_ATTN,
    // Link
    gx_if.host              bus
);

    typedef struct packed {
        gx_pkg::gx_mst_e st;
        logic [15:0]     div;
        logic [1:0]      q;
        logic [3:0]      bitn;
        logic [2:0]      step;
        logic [7:0]      sh;
        logic            rx;
        logic [1:0]      op;
        logic [6:0]      addr;
        logic [7:0]      cmd;
        logic [7:0]      wdata;
        logic [7:0]      rdata;
        logic            nack;
        logic            done;
        logic            scl_oe;
        logic            sda_oe;
        logic            rst_low;
    } gx_mst_s;

    localparam gx_mst_s MST_RST = '{st: gx_pkg::M_IDLE, default: '0};
    localparam logic [15:0] Q_LAST = 16'(QUARTER - 1);
    localparam logic [15:0] R_LEN  = 16'(RST_CYC);

    gx_mst_s    r;
    gx_mst_s    next_r;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] filt;
    logic       tick;
    logic       sda_f;
    logic [9:0] plan;

    // Sequence of each operation: kind and byte for a step
    function automatic logic [9:0] plan_of(input gx_mst_s s, input logic [2:0] k);
        logic [7:0] aw;
        logic [7:0] ar;
        aw = {s.addr, gx_pkg::DIR_WRITE};
        ar = {s.addr, gx_pkg::DIR_READ};
        plan_of = {gx_pkg::K_STOP, 8'h00};
        case (s.op)
            gx_pkg::OP_WRITE: begin
                case (k)
                    3'h0:    plan_of = {gx_pkg::K_START, 8'h00};
                    3'h1:    plan_of = {gx_pkg::K_TX, aw};
                    3'h2:    plan_of = {gx_pkg::K_TX, s.cmd};
                    3'h3:    plan_of = {gx_pkg::K_TX, s.wdata};
                    default: plan_of = {gx_pkg::K_STOP, 8'h00};
                endcase
            end
            gx_pkg::OP_READ: begin
                case (k)
                    3'h0, 3'h3: plan_of = {gx_pkg::K_START, 8'h00};
                    3'h1:       plan_of = {gx_pkg::K_TX, aw};
                    3'h2:       plan_of = {gx_pkg::K_TX, s.cmd};
                    3'h4:       plan_of = {gx_pkg::K_TX, ar};
                    3'h5:       plan_of = {gx_pkg::K_RX, 8'h00};
                    default:    plan_of = {gx_pkg::K_STOP, 8'h00};
                endcase
            end
            default: begin
                case (k)
                    3'h0:    plan_of = {gx_pkg::K_START, 8'h00};
                    3'h1:    plan_of = {gx_pkg::K_TX, ar};
                    3'h2:    plan_of = {gx_pkg::K_RX, 8'h00};
                    default: plan_of = {gx_pkg::K_STOP, 8'h00};
                endcase
            end
        endcase
    endfunction

    // Attention and data lines are pins: three-stage filter
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            sy1  <= 2'h3;
            sy2  <= 2'h3;
            sy3  <= 2'h3;
            filt <= 2'h3;
        end else begin
            sy1  <= {bus.int_n, bus.sda};
            sy2  <= sy1;
            sy3  <= sy2;
            filt <= ((sy2 ^ sy3) & filt) | (~(sy2 ^ sy3) & sy3);
        end
    end

    assign sda_f = filt[0];
    assign tick  = (r.div == Q_LAST);
    assign plan  = plan_of(r, r.step + 3'h1);

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            r <= MST_RST;
        end else begin
            r <= next_r;
        end
    end

    // Quarter-period sequencer
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        next_r.div  = tick ? 16'h0000 : r.div + 16'h0001;
        if (tick && r.st != gx_pkg::M_IDLE && r.st != gx_pkg::M_RESET) begin
            next_r.q = r.q + 2'h1;
        end
        case (r.st)
            gx_pkg::M_IDLE: begin
                next_r.div = 16'h0000;
                if (I_REQ) begin
                    next_r.op   = I_OP;
                    next_r.addr = {gx_pkg::ADDR_BASE, I_ADDR_SEL};
                    next_r.cmd  = I_CMD;
                    next_r.wdata = I_WDATA;
                    next_r.step = 3'h0;
                    next_r.q    = 2'h0;
                    next_r.nack = 1'b0;
                    next_r.st   = (I_OP == gx_pkg::OP_RESET) ? gx_pkg::M_RESET : gx_pkg::M_START;
                end
            end
            gx_pkg::M_RESET: begin
                // Hold the reset line low for at least the minimum pulse width
                next_r.rst_low = 1'b1;
                // Count past the quarter wrap so long pulses still end
                next_r.div     = r.div + 16'h0001;
                if (r.div == R_LEN) begin
                    next_r.rst_low = 1'b0;
                    next_r.done    = 1'b1;
                    next_r.st      = gx_pkg::M_IDLE;
                end
            end
            gx_pkg::M_START, gx_pkg::M_STOP: begin
                if (tick) begin
                    case (r.q)
                        2'h0:    next_r.sda_oe = (r.st == gx_pkg::M_STOP);
                        2'h1:    next_r.scl_oe = 1'b0;
                        2'h2:    next_r.sda_oe = (r.st == gx_pkg::M_START);
                        default: next_r.scl_oe = (r.st == gx_pkg::M_START);
                    endcase
                    if (r.q == 2'h3 && r.st == gx_pkg::M_STOP) begin
                        next_r.st   = gx_pkg::M_IDLE;
                        next_r.done = 1'b1;
                    end
                end
            end
            gx_pkg::M_BYTE: begin
                if (tick) begin
                    case (r.q)
                        2'h0:    next_r.sda_oe = ~r.rx & (r.bitn != 4'h8) & ~r.sh[7];
                        2'h1:    next_r.scl_oe = 1'b0;
                        2'h2: begin
                            if (r.bitn != 4'h8) begin
                                next_r.sh = {r.sh[6:0], sda_f};
                            end else if (!r.rx) begin
                                next_r.nack = sda_f;
                            end
                        end
                        default: begin
                            next_r.scl_oe = 1'b1;
                            next_r.bitn   = r.bitn + 4'h1;
                        end
                    endcase
                end
            end
            default: begin
                next_r.st = gx_pkg::M_IDLE;
            end
        endcase
        // Advance to the next item after a start or a finished byte
        if (tick && r.q == 2'h3 && (r.st == gx_pkg::M_START ||
            (r.st == gx_pkg::M_BYTE && r.bitn == 4'h8))) begin
            if (r.st == gx_pkg::M_BYTE && r.rx) begin
                next_r.rdata = r.sh;
            end
            next_r.step = r.step + 3'h1;
            next_r.bitn = 4'h0;
            next_r.rx   = (plan[9:8] == gx_pkg::K_RX);
            next_r.sh   = plan[7:0];
            case (plan[9:8])
                gx_pkg::K_START: next_r.st = gx_pkg::M_START;
                gx_pkg::K_STOP:  next_r.st = gx_pkg::M_STOP;
                default:         next_r.st = gx_pkg::M_BYTE;
            endcase
            if (r.st == gx_pkg::M_BYTE && !r.rx && next_r.nack) begin
                next_r.st = gx_pkg::M_STOP;
            end
        end
    end

    assign bus.m_scl_oe = r.scl_oe;
    assign bus.m_sda_oe = r.sda_oe;
    assign bus.rst_n    = ~r.rst_low;

    assign O_READY = (r.st == gx_pkg::M_IDLE);
    assign O_DONE  = r.done;
    assign O_NACK  = r.nack;
    assign O_RDATA = r.rdata;
    assign O_ATTN  = ~filt[1];

endmodule

/* gx_asserts.sv */
// Purpose: Link checks between master and expander.
// Assumes: Master built with QUARTER 8 and RST_CYC 8.
// Notes:   Sees only the lines, so pin-side behaviour is judged by the bench.
`timescale 1ns/1ps
module gx_asserts (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // Joined lines
    input wire logic m_sda_oe,
    input wire logic s_sda_oe,
    input wire logic s_int_oe,
    input wire logic rst_n,
    input wire logic scl,
    input wire logic sda
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_N);
    // Reset line gets a filter delay before it bites
    property p_rst_quiet; !rst_n[*6] |-> !s_int_oe && !s_sda_oe; endproperty
    property p_int_run; $rose(s_int_oe) |-> rst_n; endproperty
    property p_rst_width; $fell(rst_n) |=> !rst_n[*7]; endproperty
    // Slave moves data only while the clock is low
    property p_slv_edge; $changed(s_sda_oe) |-> !scl || !rst_n; endproperty
    property p_start_own; $fell(sda) && scl |-> m_sda_oe; endproperty
    property p_sda_hold; scl && $past(scl) && $changed(sda) |-> $changed(m_sda_oe); endproperty
    // At least one quarter low and high with QUARTER 8
    property p_scl_low; $fell(scl) |=> !scl[*8]; endproperty
    property p_scl_high; $rose(scl) |=> scl[*7]; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("lines driven in reset");
    a_int_run: assert property (p_int_run) else $error("attention during reset");
    a_rst_width: assert property (p_rst_width) else $error("reset pulse short");
    a_slv_edge: assert property (p_slv_edge) else $error("slave data moved, clock high");
    a_start_own: assert property (p_start_own) else $error("start not from master");
    a_sda_hold: assert property (p_sda_hold) else $error("data moved, clock high");
    a_scl_low: assert property (p_scl_low) else $error("clock low too short");
    a_scl_high: assert property (p_scl_high) else $error("clock high too short");
    c_ack: cover property ($rose(s_sda_oe));
    c_int: cover property ($rose(s_int_oe));
    c_clr: cover property ($fell(s_int_oe));
    c_rst: cover property ($fell(rst_n));
endmodule

/* gx_test.sv */
// Purpose: Runs master requests and pin changes against the expander.
// Assumes: Short link timing (QUARTER 8, RST_CYC 8) keeps the run brief.
// Notes:   Attention reaches the master about ten clocks after a pin; twelve leave margin.
`timescale 1ns/1ps
module gx_test;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       req = 1'b0;
    logic [1:0] op = 2'h0;
    logic       sel = 1'b0;
    logic       xsel = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic [7:0] wd = 8'h00;
    logic [7:0] pins = 8'h00;
    logic       ready, done, nack, attn;
    logic [7:0] rdata, o_p, o_oe;
    int         bad_count = 0;
    int         checks = 0;
    int         cyc = 0;
    gx_if bus_if ();
    gx_expander gx_expander_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .bus(bus_if),
        .I_P(pins), .O_P(o_p), .O_P_OE(o_oe), .I_ADDR_SEL(xsel));
    gx_master #(.QUARTER(8), .RST_CYC(8)) gx_master_inst (.I_REF_CLK(clk), .I_RST_N(rst_n),
        .I_REQ(req), .I_OP(op), .I_ADDR_SEL(sel), .I_CMD(cmd), .I_WDATA(wd), .O_READY(ready),
        .O_DONE(done), .O_NACK(nack), .O_RDATA(rdata), .O_ATTN(attn), .bus(bus_if));
    gx_asserts gx_asserts_inst (.I_REF_CLK(clk), .I_RST_N(rst_n), .m_sda_oe(bus_if.m_sda_oe),
        .s_sda_oe(bus_if.s_sda_oe), .s_int_oe(bus_if.s_int_oe), .rst_n(bus_if.rst_n),
        .scl(bus_if.scl), .sda(bus_if.sda));
    // Clock and hang guard; a run needs about 6400 cycles
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("Counts: checks=%0d mismatches=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One request, then wait on the done pulse at settled edges
    task automatic run(input logic [1:0] o, input logic s, input logic [7:0] c, d);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        op <= o;
        sel <= s;
        cmd <= c;
        wd <= d;
        @(posedge clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        // A request that never finishes counts against the run
        if (n == 5000) begin
            bad_count++;
        end
    endtask
    task automatic pin(input logic [7:0] v);
        @(posedge clk);
        pins <= v;
        repeat (12) @(posedge clk);
        @(negedge clk);
    endtask
    // Main sequence: registers, attention, direct read, reset pulse
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        cmp(o_p, 8'hff);
        run(2'h0, 1'b0, 8'h03, 8'h0f);
        // Pins sit at zero against a reset filter of ones: no boot attention
        cmp({7'h0, attn}, 8'h00);
        cmp({7'h0, ready}, 8'h01);
        run(2'h0, 1'b0, 8'h01, 8'h5a);
        cmp(o_oe, 8'hf0);
        cmp(o_p, 8'h5a);
        run(2'h1, 1'b0, 8'h03, 8'h00);
        cmp(rdata, 8'h0f);
        $display("registers done");
        pin(8'h01);
        cmp({7'h0, attn}, 8'h01);
        pin(8'h00);
        cmp({7'h0, attn}, 8'h00);
        pin(8'h80);
        cmp({7'h0, attn}, 8'h00);
        pin(8'h82);
        run(2'h0, 1'b1, 8'h00, 8'h00);
        cmp({7'h0, nack}, 8'h01);
        cmp({7'h0, attn}, 8'h01);
        run(2'h1, 1'b0, 8'h00, 8'h00);
        cmp(rdata, 8'h82);
        cmp({7'h0, attn}, 8'h00);
        pin(8'h83);
        cmp({7'h0, attn}, 8'h01);
        run(2'h2, 1'b0, 8'h00, 8'h00);
        cmp(rdata, 8'h83);
        cmp({7'h0, attn}, 8'h00);
        $display("attention done");
        run(2'h3, 1'b0, 8'h00, 8'h00);
        cmp(o_p, 8'hff);
        cmp(o_oe, 8'h00);
        cmp({7'h0, attn}, 8'h00);
        // Strap the expander high: the upper address must now be answered
        @(posedge clk);
        xsel <= 1'b1;
        run(2'h0, 1'b1, 8'h01, 8'h3c);
        cmp({7'h0, nack}, 8'h00);
        cmp(o_p, 8'h3c);
        $display("reset done");
        wrap_up();
    end
endmodule
